// ### core/aisr_pkg.sv
// Purpose: Shared constants and types for the interrupt status register block.
// Assumes: Eight-bit register read port, one clock domain, host reads only.
// Notes:   Offsets, field positions and reset values are named here once.
// Function
// - Event flags set by engines, kept per latch mode
// - First register: flat,orient,taps,slow,slope,high,low
// - Second register: data ready, watermark, full, reserved
// - Tap sign bit 7, axes z,y,x bits 6-4
// - Slope sign bit 3, axes z,y,x bits 2-0
// - Fourth register bit 7 shows flat position
// - Bit 6 shows z upward or downward
// - Bits 5:4 encode the in-plane orientation
// - Orientation bits ignore the latch mode
// - Orientation bits freeze while blocking condition holds
// - High-g sign bit 3, axes z,y,x bits 2-0
package aisr_pkg;

   // Register offsets on the serial register map.
   localparam logic [7:0] MOTION_EVENT_FLAGS_OFS        = 8'h09;
   localparam logic [7:0] DATA_BUFFER_EVENT_FLAGS_OFS   = 8'h0a;
   localparam logic [7:0] TAP_SLOPE_SOURCE_INFO_OFS     = 8'h0b;
   localparam logic [7:0] POSITION_LARGE_ACCEL_INFO_OFS = 8'h0c;
   localparam logic [7:0] RESERVED_SLOT_OFS             = 8'h0d;

   // Reset value of every stored bit and of reserved or unmapped reads.
   localparam logic [7:0] STATUS_RESET_VAL = 8'h00;
   localparam logic [7:0] RESERVED_READ    = 8'h00;

   // Positions of the event flags in the internal event vector.
   localparam int EV_FLAT      = 10;
   localparam int EV_ORIENT    = 9;
   localparam int EV_SINGLE    = 8;
   localparam int EV_DOUBLE    = 7;
   localparam int EV_SLOWMOT   = 6;
   localparam int EV_SLOPE     = 5;
   localparam int EV_HIGH      = 4;
   localparam int EV_LOW       = 3;
   localparam int EV_DATA      = 2;
   localparam int EV_THRESHOLD = 1;
   localparam int EV_FULL      = 0;
   localparam int EV_COUNT     = 11;

   // Field positions inside the fourth status register.
   localparam int FLAT_BIT      = 7;
   localparam int ORIENT_Z_BIT  = 6;
   localparam int ORIENT_XY_MSB = 5;
   localparam int ORIENT_XY_LSB = 4;

   // Index of each trigger-source group.
   localparam int SRC_TAP   = 0;
   localparam int SRC_SLOPE = 1;
   localparam int SRC_HIGH  = 2;
   localparam int SRC_COUNT = 3;

   // Retention behaviour chosen by the latch-mode setting held elsewhere.
   typedef enum logic [1:0] {
      AISR_LATCH_NONE,
      AISR_LATCH_TEMP,
      AISR_LATCH_PERM
   } aisr_latch_e;

   // Sign and axes of one trigger: sign 0 positive, 1 negative.
   typedef struct packed {
      logic       sign;
      logic [2:0] axisZyx;
   } aisr_source_s;

   // Orientation code: z half and in-plane half.
   typedef struct packed {
      logic       zDown;
      logic [1:0] plane;
   } aisr_orient_s;

   // Everything that the interrupt engines present each cycle.
   typedef struct packed {
      logic [EV_COUNT-1:0]                events;
      aisr_source_s [SRC_COUNT-1:0]       source;
      logic                               flatPosition;
      logic                               flatEnable;
      aisr_orient_s                       orient;
      logic                               orientBlock;
   } aisr_engine_s;

endpackage : aisr_pkg

// ### core/aisr_status_regs.sv
// Purpose: Read-only interrupt status registers of the accelerometer core.
// Assumes: Engines drive levels synchronous to clk; latch timer lives outside.
// Notes:   Read data is registered and appears one cycle after the strobe.
`timescale 1ns/1ps
module aisr_status_regs #(
   parameter int ADDR_W = 8
) (
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire aisr_pkg::aisr_engine_s engine,
   input  wire aisr_pkg::aisr_latch_e  latchMode,
   input  wire logic                  latchExpire,
   input  wire logic                  latchReset,
   input  wire logic                  rdStrobe,
   input  wire logic [ADDR_W-1:0]     rdAddr,
   output logic [7:0]                 rdData,
   output logic                       rdValid,
   output logic [aisr_pkg::EV_COUNT-1:0] flagsNow
);

   // Decodes a register address into a slot number, 7 meaning unmapped.
   function automatic logic [2:0] slotOf(input logic [ADDR_W-1:0] addr);
      logic [7:0] a;
      a = 8'(addr);
      if (addr > ADDR_W'(8'hff)) begin
         slotOf = 3'h7;
      end else if (a == aisr_pkg::MOTION_EVENT_FLAGS_OFS) begin
         slotOf = 3'h0;
      end else if (a == aisr_pkg::DATA_BUFFER_EVENT_FLAGS_OFS) begin
         slotOf = 3'h1;
      end else if (a == aisr_pkg::TAP_SLOPE_SOURCE_INFO_OFS) begin
         slotOf = 3'h2;
      end else if (a == aisr_pkg::POSITION_LARGE_ACCEL_INFO_OFS) begin
         slotOf = 3'h3;
      end else if (a == aisr_pkg::RESERVED_SLOT_OFS) begin
         slotOf = 3'h4;
      end else begin
         slotOf = 3'h7;
      end
   endfunction : slotOf

   // Stored state.
   logic [aisr_pkg::EV_COUNT-1:0]  flags;
   logic [aisr_pkg::EV_COUNT-1:0]  next_flags;
   aisr_pkg::aisr_source_s [aisr_pkg::SRC_COUNT-1:0] source;
   aisr_pkg::aisr_source_s [aisr_pkg::SRC_COUNT-1:0] next_source;
   aisr_pkg::aisr_orient_s         orient;
   aisr_pkg::aisr_orient_s         next_orient;
   logic                           flat;
   logic                           next_flat;
   logic [7:0]                     next_rdData;
   logic                           next_rdValid;
   logic [aisr_pkg::SRC_COUNT-1:0] srcEvent;
   logic [aisr_pkg::SRC_COUNT-1:0] srcFlag;
   logic                           clearHeld;

   // A held flag drops on a latch reset, or on expiry in temporary mode.
   always_comb begin
      clearHeld = latchReset ||
                  (latchExpire && (latchMode == aisr_pkg::AISR_LATCH_TEMP));
   end

   // Event flags: live in unlatched mode, held otherwise; a new event beats a clear.
   always_comb begin
      next_flags = flags;
      unique case (latchMode)
         aisr_pkg::AISR_LATCH_NONE: begin
            next_flags = engine.events;
         end
         aisr_pkg::AISR_LATCH_TEMP,
         aisr_pkg::AISR_LATCH_PERM: begin
            next_flags = engine.events | (flags & {aisr_pkg::EV_COUNT{~clearHeld}});
         end
         default: begin
            next_flags = engine.events;
         end
      endcase
   end

   // Map each source group onto the events that trigger it.
   always_comb begin
      srcEvent = '0;
      srcFlag  = '0;
      srcEvent[aisr_pkg::SRC_TAP]   = engine.events[aisr_pkg::EV_SINGLE] |
                                      engine.events[aisr_pkg::EV_DOUBLE];
      srcEvent[aisr_pkg::SRC_SLOPE] = engine.events[aisr_pkg::EV_SLOPE];
      srcEvent[aisr_pkg::SRC_HIGH]  = engine.events[aisr_pkg::EV_HIGH];
      srcFlag[aisr_pkg::SRC_TAP]    = flags[aisr_pkg::EV_SINGLE] |
                                      flags[aisr_pkg::EV_DOUBLE];
      srcFlag[aisr_pkg::SRC_SLOPE]  = flags[aisr_pkg::EV_SLOPE];
      srcFlag[aisr_pkg::SRC_HIGH]   = flags[aisr_pkg::EV_HIGH];
   end

   // Sign and axes follow the event that set their group and are held with it.
   for (genvar g = 0; g < aisr_pkg::SRC_COUNT; g++) begin : gSource
      always_comb begin
         next_source[g] = source[g];
         if (latchMode == aisr_pkg::AISR_LATCH_NONE) begin
            next_source[g] = engine.source[g];
         end else if (srcEvent[g]) begin
            next_source[g] = engine.source[g];
         end else if (srcFlag[g] && clearHeld) begin
            next_source[g] = '0;
         end
      end
   end

   // Orientation ignores the latch mode and freezes while blocked.
   always_comb begin
      next_orient = orient;
      if (!engine.orientBlock) begin
         next_orient = engine.orient;
      end
   end

   // Flat position is a live level, shown as zero while detection is off.
   always_comb begin
      next_flat = engine.flatPosition & engine.flatEnable;
   end

   // Read multiplexer; reserved and unmapped locations read as zero.
   always_comb begin
      next_rdValid = rdStrobe;
      next_rdData  = rdData;
      if (rdStrobe) begin
         unique case (slotOf(rdAddr))
            3'h0: begin
               next_rdData = flags[aisr_pkg::EV_FLAT:aisr_pkg::EV_LOW];
            end
            3'h1: begin
               next_rdData = {flags[aisr_pkg::EV_DATA:aisr_pkg::EV_FULL], 5'h00};
            end
            3'h2: begin
               next_rdData = {source[aisr_pkg::SRC_TAP], source[aisr_pkg::SRC_SLOPE]};
            end
            3'h3: begin
               next_rdData = {flat, orient, source[aisr_pkg::SRC_HIGH]};
            end
            3'h4: begin
               next_rdData = aisr_pkg::RESERVED_READ;
            end
            default: begin
               next_rdData = aisr_pkg::RESERVED_READ;
            end
         endcase
      end
   end

   // Status state registers.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags  <= '0;
         source <= '0;
         orient <= '0;
         flat   <= 1'b0;
      end else begin
         flags  <= next_flags;
         source <= next_source;
         orient <= next_orient;
         flat   <= next_flat;
      end
   end

   // Read port registers.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdData  <= aisr_pkg::STATUS_RESET_VAL;
         rdValid <= 1'b0;
      end else begin
         rdData  <= next_rdData;
         rdValid <= next_rdValid;
      end
   end

   // Held flags are offered to the pin-mapping logic elsewhere.
   assign flagsNow = flags;

endmodule : aisr_status_regs

// ### bench/aisr_props.sv
// Purpose: Port assertions for the interrupt status register block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   A read shows the state held at the edge of its strobe.
`timescale 1ns/1ps
module aisr_props #(
   parameter int ADDR_W = 8
) (
   input wire logic                          clk,
   input wire logic                          rstn,
   input wire aisr_pkg::aisr_engine_s        engine,
   input wire aisr_pkg::aisr_latch_e         latchMode,
   input wire logic                          latchExpire,
   input wire logic                          latchReset,
   input wire logic                          rdStrobe,
   input wire logic [ADDR_W-1:0]             rdAddr,
   input wire logic [7:0]                    rdData,
   input wire logic                          rdValid,
   input wire logic [aisr_pkg::EV_COUNT-1:0] flagsNow
);
   // Every check runs on the rising edge and rests during reset.
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_read_answered: assert property (rdStrobe |=> rdValid) else $error("no answer");
   a_rsvd_zero: assert property (rdStrobe && rdAddr == 8'h0d |=> rdData == 8'h00)
      else $error("reserved slot not zero");
   a_flag_map: assert property (rdStrobe && rdAddr == 8'h09
      |=> rdData == $past(flagsNow[10:3])) else $error("flag byte wrong");
   a_none_follow: assert property (latchMode == aisr_pkg::AISR_LATCH_NONE
      |=> flagsNow == $past(engine.events)) else $error("unlatched flag lags");
   a_latch_set: assert property (latchMode != aisr_pkg::AISR_LATCH_NONE
      |=> (flagsNow & $past(engine.events)) == $past(engine.events)) else $error("not set");
   a_perm_hold: assert property (latchMode == aisr_pkg::AISR_LATCH_PERM && !latchReset
      |=> (flagsNow & $past(flagsNow)) == $past(flagsNow)) else $error("flag dropped");
   a_reset_clears: assert property (latchReset && engine.events == '0 |=> flagsNow == '0)
      else $error("latch reset ignored");
   a_temp_expire: assert property (latchMode == aisr_pkg::AISR_LATCH_TEMP && latchExpire
      && engine.events == '0 |=> flagsNow == '0) else $error("expiry ignored");
   // Main scenarios reached.
   c_read_pos: cover property (rdStrobe && rdAddr == 8'h0c);
   c_perm_reset: cover property (latchMode == aisr_pkg::AISR_LATCH_PERM && latchReset);
   c_blocked: cover property (engine.orientBlock && rdStrobe);
endmodule : aisr_props

bind aisr_status_regs aisr_props #(.ADDR_W(ADDR_W)) u_props (.clk(clk), .rstn(rstn),
   .engine(engine), .latchMode(latchMode), .latchExpire(latchExpire), .latchReset(latchReset),
   .rdStrobe(rdStrobe), .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid), .flagsNow(flagsNow));

// ### bench/aisr_host_model.sv
// Purpose: Host that reads the status registers one byte at a time.
// Assumes: Requests change at the falling edge and are taken on the next rise.
// Notes:   A released address shows the inverse of the last one.
`timescale 1ns/1ps
module aisr_host_model (
   input  wire logic       clk,
   output logic            rdStrobe,
   output logic [7:0]      rdAddr,
   input  wire logic [7:0] rdData,
   input  wire logic       rdValid
);
   // Idle bus at start.
   initial begin
      rdStrobe = 1'b0;
      rdAddr = 8'h00;
   end

   // One read; a missing answer returns unknown so the caller sees it.
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      rdStrobe = 1'b1;
      rdAddr = a;
      @(posedge clk);
      @(negedge clk);
      d = (rdValid === 1'b1) ? rdData : 8'hxx;
      rdStrobe = 1'b0;
      rdAddr = ~a;
   endtask : read_reg
endmodule : aisr_host_model

// ### bench/testbench.sv
// Purpose: Self-checking bench for the status register block.
// Assumes: Engine levels change at the falling edge; host model reads.
// Notes:   Expected bytes come from exp_reg and a tracked orientation, or from the burst snapshot per mode.
`timescale 1ns/1ps
module testbench;
   logic                   clk = 1'b0;
   logic                   rstn = 1'b0;
   aisr_pkg::aisr_engine_s engine = '0;
   aisr_pkg::aisr_engine_s burst;
   aisr_pkg::aisr_latch_e  latchMode = aisr_pkg::AISR_LATCH_NONE;
   logic                   latchExpire = 1'b0;
   logic                   latchReset = 1'b0;
   logic                   rdStrobe;
   logic [7:0]             rdAddr;
   logic [7:0]             rdData;
   logic                   rdValid;
   logic [7:0]             got;
   aisr_pkg::aisr_orient_s held = '0;
   integer                 seed = 23;
   integer                 error_cnt = 0;
   integer                 samples_checked = 0;

   // Clock of 10 ns period.
   always #5 clk = ~clk;

   aisr_status_regs u_dut (.clk(clk), .rstn(rstn), .engine(engine), .latchMode(latchMode),
      .latchExpire(latchExpire), .latchReset(latchReset), .rdStrobe(rdStrobe),
      .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid), .flagsNow());
   aisr_host_model u_host (.clk(clk), .rdStrobe(rdStrobe), .rdAddr(rdAddr),
      .rdData(rdData), .rdValid(rdValid));

   // Register image for an engine snapshot and the orientation last let through.
   function automatic logic [7:0] exp_reg(input logic [7:0] a, input aisr_pkg::aisr_engine_s e,
                                          input aisr_pkg::aisr_orient_s o);
      case (a)
         8'h09: return e.events[10:3];
         8'h0a: return {e.events[2:0], 5'h00};
         8'h0b: return {e.source[0], e.source[1]};
         8'h0c: return {e.flatPosition & e.flatEnable, o, e.source[2]};
         default: return 8'h00;
      endcase
   endfunction : exp_reg

   // Compares one seen value with its expectation and counts a difference.
   task automatic check(input logic [7:0] a, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch reg_%h expected %h seen %h", a, exp, seen);
      end
   endtask : check

   // Reads one register and hands the byte to the compare task.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      u_host.read_reg(a, got);
      check(a, got, exp);
   endtask : rd_chk

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop

   // Random unlatched snapshots, then one burst per retention mode.
   initial begin
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(negedge clk);
         engine = aisr_pkg::aisr_engine_s'($random(seed));
         if (!engine.orientBlock) held = engine.orient;
         for (int a = 8; a < 15; a++) rd_chk(8'(a), exp_reg(8'(a), engine, held));
      end
      for (int m = 0; m < 3; m++) begin
         @(negedge clk);
         latchMode = aisr_pkg::aisr_latch_e'(m);
         engine.events = 11'($random(seed)) | 11'h130;
         engine.source = 12'($random(seed));
         engine.orientBlock = 1'b0;
         engine.orient = 3'($random(seed));
         held = engine.orient;
         burst = engine;
         @(negedge clk);
         engine.events = '0;
         engine.source = '0;
         latchExpire = 1'b1;
         @(negedge clk);
         latchExpire = 1'b0;
         rd_chk(8'h09, m == 2 ? burst.events[10:3] : 8'h00);
         rd_chk(8'h0b, m == 2 ? {burst.source[0], burst.source[1]} : 8'h00);
         latchReset = 1'b1;
         @(negedge clk);
         latchReset = 1'b0;
         rd_chk(8'h09, 8'h00);
         rd_chk(8'h0c, exp_reg(8'h0c, engine, held));
      end
      report_and_stop();
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      #100000;
      error_cnt++;
      report_and_stop();
   end
endmodule : testbench
